// File: rtl/hofc_cfg_parity.sv
// hofc_cfg_parity: row and column parity check of the configuration lines
// assumes the memory image is stable logic on the same clock
`timescale 1ns/100ps
module hofc_cfg_parity (
	input  wire logic                                       clock,       // system clock
	input  wire logic                                       arst_n,      // async reset
	input  wire logic [hofc_pkg::NLINES*hofc_pkg::LINE_W-1:0] cfg_image,   // raw lines
	input  wire logic [hofc_pkg::NLINES-1:0]                cfg_row_par, // parity per line
	input  wire logic [hofc_pkg::LINE_W-1:0]                cfg_col_par, // column parity
	output logic      [hofc_pkg::NLINES*hofc_pkg::LINE_W-1:0] fixed_r,     // corrected lines
	output logic                                            fix_r,       // one bit fixed
	output logic                                            uncorr_r     // not correctable
);
	logic [hofc_pkg::NLINES-1:0]                row_bad;
	logic [hofc_pkg::LINE_W-1:0]                col_syn;
	logic [hofc_pkg::NLINES*hofc_pkg::LINE_W-1:0] fixed_nxt;
	logic                                       single;
	logic                                       col_one;

	// column syndrome over all lines
	always_comb
	begin
		col_syn = cfg_col_par;
		for (int i = 0; i < hofc_pkg::NLINES; i++)
		begin
			col_syn = col_syn ^ cfg_image[i*hofc_pkg::LINE_W +: hofc_pkg::LINE_W];
		end
	end

	// one bad line with one bad column is fixable
	assign col_one = (col_syn != '0) && ((col_syn & (col_syn - 16'h0001)) == '0);
	assign single  = ($countones(row_bad) == 1) && col_one;

	// per line parity check and bit flip
	genvar g;
	generate
		for (g = 0; g < hofc_pkg::NLINES; g++)
		begin : g_line
			assign row_bad[g] = (^cfg_image[g*hofc_pkg::LINE_W +: hofc_pkg::LINE_W])
				^ cfg_row_par[g];
			assign fixed_nxt[g*hofc_pkg::LINE_W +: hofc_pkg::LINE_W] =
				cfg_image[g*hofc_pkg::LINE_W +: hofc_pkg::LINE_W]
				^ ((row_bad[g] && single) ? col_syn : '0);
		end
	endgenerate

	// registered result
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fixed_r  <= '0;
			fix_r    <= 1'b0;
			uncorr_r <= 1'b0;
		end
		else
		begin
			fixed_r  <= fixed_nxt;
			fix_r    <= single;
			uncorr_r <= !single && ((row_bad != '0) || (col_syn != '0));
		end
	end

	a_two_lines: assert property (@(posedge clock) disable iff (!arst_n)
		($countones(row_bad) > 1) |=> (uncorr_r && !fix_r))
		else $error("two bad lines not flagged");
endmodule : hofc_cfg_parity

// File: rtl/hofc_pkg.sv
// hofc_pkg: constants shared by the hall output filter and clamp block
// assumes a single 100 MHz clock and a 32-bit avalon-mm register port
package hofc_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ        = 100_000_000;
	localparam int INTERP_HZ     = 256_000;
	localparam int LP_HZ         = 16_000;
	// rounds down, so the period is slightly short of the exact rate
	localparam int INTERP_CYC    = CLK_HZ / INTERP_HZ;
	localparam int INTERP_PER_LP = INTERP_HZ / LP_HZ;
	localparam logic [8:0] INTERP_LAST = 9'(INTERP_CYC - 1);
	localparam logic [3:0] PHASE_LAST  = 4'(INTERP_PER_LP - 1);

	// ****************************************
	// data path
	// ****************************************
	localparam int ADC_W  = 16;
	localparam int CODE_W = 12;
	localparam int FRAC_W = 12;
	localparam logic [2:0]  LP_BYPASS = 3'h7;
	// one-pole coefficients in q12 for 78..1320 hz at 16 khz
	localparam logic [11:0] LP_COEF [0:6] = '{12'h07c, 12'h176, 12'h26f, 12'h36e,
		12'h46d, 12'h571, 12'h677};
	localparam logic [11:0] CODE_FULL = 12'hfff;
	localparam logic [11:0] CODE_MID  = 12'h800;

	// ****************************************
	// configuration memory
	// ****************************************
	localparam int NLINES = 3;
	localparam int LINE_W = 16;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [4:0] OFS_LP     = 5'h00;
	localparam logic [4:0] OFS_CL     = 5'h04;
	localparam logic [4:0] OFS_CH     = 5'h08;
	localparam logic [4:0] OFS_CTRL   = 5'h0c;
	localparam logic [4:0] OFS_STATUS = 5'h10;
	localparam logic [2:0]  RST_LP    = 3'h0;
	localparam logic [11:0] RST_CL    = 12'h000;
	localparam logic [11:0] RST_CH    = 12'hfff;
	localparam logic        RST_CTRL  = 1'b0;
	localparam int ST_UNCORR_BIT = 0;
	localparam int ST_FIX_BIT    = 1;
	localparam int ST_CODE_LSB   = 16;
endpackage : hofc_pkg

// File: rtl/hofc_top.sv
// hofc_top: hall sample low-pass, limiter, interpolation and output clamp
// assumes adc samples and memory image come from logic on the same clock
//
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
module hofc_top (
	input  wire logic                 clock,       // 100 mhz system clock
	input  wire logic                 arst_n,      // async reset, active low
	input  wire logic [15:0]          adc_data,    // signed hall adc sample
	input  wire logic                 adc_valid,   // sample strobe
	input  wire logic [47:0]          cfg_image,   // configuration lines
	input  wire logic [2:0]           cfg_row_par, // parity per line
	input  wire logic [15:0]          cfg_col_par, // column parity
	input  wire logic [4:0]           address,     // avalon byte address
	input  wire logic                 read,        // avalon read
	input  wire logic                 write,       // avalon write
	input  wire logic [31:0]          writedata,   // avalon write data
	input  wire logic [3:0]           byteenable,  // avalon byte lanes
	output logic      [31:0]          readdata,    // avalon read data
	output logic                      waitrequest, // avalon stall
	output logic      [11:0]          dac_code,    // output dac code
	output logic                      dac_strobe,  // new dac code pulse
	output logic                      cfg_error    // uncorrectable memory error
);
	// ****************************************
	// declarations
	// ****************************************
	logic [2:0]         lp_r;
	logic [11:0]        cl_r;
	logic [11:0]        ch_r;
	logic               ctrl_r;
	logic [31:0]        readdata_r;
	logic               wait_r;
	logic [31:0]        rd_nxt;
	logic               acc_ok;
	logic [47:0]        fixed;
	logic               fix;
	logic               uncorr;
	logic [2:0]         lp_eff;
	logic [11:0]        lo_eff;
	logic [11:0]        hi_eff;
	logic [8:0]         tick_cnt_r;
	logic               interp_tick;
	logic [3:0]         phase_r;
	logic               lp_tick;
	logic [12:0]        lp_gap_r;
	logic               lp_seen_r;
	logic signed [15:0] sample_r;
	logic signed [27:0] filt_r;
	logic signed [27:0] filt_nxt;
	logic signed [27:0] x_ext;
	logic signed [28:0] diff;
	logic signed [41:0] prod;
	logic signed [15:0] filt_int;
	logic [11:0]        dsp_code;
	logic [15:0]        acc_r;
	logic [15:0]        acc_sum;
	logic signed [12:0] delta_r;
	logic [11:0]        interp_code;
	logic [11:0]        lo_c;
	logic [11:0]        out_nxt;
	logic [11:0]        dac_code_r;
	logic               dac_strobe_r;

	// ****************************************
	// avalon register slave
	// ****************************************
	// one wait cycle, answer when waitrequest is low
	assign acc_ok = (read || write) && !wait_r;

	// waitrequest drops for one cycle per request
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			wait_r <= 1'b1;
		else
			wait_r <= !((read || write) && wait_r);
	end

	// read mux, unmapped offsets read zero
	always_comb
	begin
		rd_nxt = 32'h0000_0000;
		case (address)
			hofc_pkg::OFS_LP:     rd_nxt[2:0]  = lp_r;
			hofc_pkg::OFS_CL:     rd_nxt[11:0] = cl_r;
			hofc_pkg::OFS_CH:     rd_nxt[11:0] = ch_r;
			hofc_pkg::OFS_CTRL:   rd_nxt[0]    = ctrl_r;
			hofc_pkg::OFS_STATUS:
			begin
				rd_nxt[hofc_pkg::ST_UNCORR_BIT] = uncorr;
				rd_nxt[hofc_pkg::ST_FIX_BIT]    = fix;
				rd_nxt[hofc_pkg::ST_CODE_LSB +: 12] = dac_code_r;
			end
			default:              rd_nxt = 32'h0000_0000;
		endcase
	end

	// read data registered while the wait cycle runs
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			readdata_r <= 32'h0000_0000;
		else if (read && wait_r)
			readdata_r <= rd_nxt;
	end

	// writable registers, byte lanes honoured
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lp_r   <= hofc_pkg::RST_LP;
			cl_r   <= hofc_pkg::RST_CL;
			ch_r   <= hofc_pkg::RST_CH;
			ctrl_r <= hofc_pkg::RST_CTRL;
		end
		else if (write && acc_ok)
		begin
			case (address)
				hofc_pkg::OFS_LP:
					if (byteenable[0]) lp_r <= writedata[2:0];
				hofc_pkg::OFS_CL:
				begin
					if (byteenable[0]) cl_r[7:0]  <= writedata[7:0];
					if (byteenable[1]) cl_r[11:8] <= writedata[11:8];
				end
				hofc_pkg::OFS_CH:
				begin
					if (byteenable[0]) ch_r[7:0]  <= writedata[7:0];
					if (byteenable[1]) ch_r[11:8] <= writedata[11:8];
				end
				hofc_pkg::OFS_CTRL:
					if (byteenable[0]) ctrl_r <= writedata[0];
				default: ;
			endcase
		end
	end

	a_bus_wait: assert property (@(posedge clock) disable iff (!arst_n)
		((read || write) && waitrequest) |=> (!waitrequest ##1 waitrequest))
		else $error("waitrequest not one wait cycle");

	// ****************************************
	// configuration source
	// ****************************************
	hofc_cfg_parity u_parity (
		.clock       (clock),
		.arst_n      (arst_n),
		.cfg_image   (cfg_image),
		.cfg_row_par (cfg_row_par),
		.cfg_col_par (cfg_col_par),
		.fixed_r     (fixed),
		.fix_r       (fix),
		.uncorr_r    (uncorr)
	);

	// ctrl bit0 selects the ram registers over the corrected memory
	assign lp_eff = ctrl_r ? lp_r : fixed[2:0];
	assign lo_eff = ctrl_r ? cl_r : fixed[27:16];
	assign hi_eff = ctrl_r ? ch_r : fixed[43:32];

	// ****************************************
	// rate generation
	// ****************************************
	// 256 khz tick, 16 khz tick every sixteenth of it
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tick_cnt_r <= 9'h000;
			phase_r    <= 4'h0;
		end
		else if (interp_tick)
		begin
			tick_cnt_r <= 9'h000;
			phase_r    <= (phase_r == hofc_pkg::PHASE_LAST) ? 4'h0 : phase_r + 4'h1;
		end
		else
			tick_cnt_r <= tick_cnt_r + 9'h001;
	end

	assign interp_tick = (tick_cnt_r == hofc_pkg::INTERP_LAST);
	assign lp_tick     = interp_tick && (phase_r == hofc_pkg::PHASE_LAST);

	a_interp_rate: assert property (@(posedge clock) disable iff (!arst_n)
		interp_tick |=> (!interp_tick)[*8] ##[382:382] interp_tick)
		else $error("interpolation tick spacing wrong");

	// helper count of cycles since the last low-pass update
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lp_gap_r  <= 13'h0000;
			lp_seen_r <= 1'b0;
		end
		else if (lp_tick)
		begin
			lp_gap_r  <= 13'h0000;
			lp_seen_r <= 1'b1;
		end
		else
			lp_gap_r <= lp_gap_r + 13'h0001;
	end

	a_lp_rate: assert property (@(posedge clock) disable iff (!arst_n)
		(lp_tick && lp_seen_r) |->
		(lp_gap_r == 13'(hofc_pkg::INTERP_CYC * hofc_pkg::INTERP_PER_LP - 1)))
		else $error("low-pass update spacing wrong");

	// ****************************************
	// input low-pass filter
	// ****************************************
	// hold the latest adc sample
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			sample_r <= 16'sh0000;
		else if (adc_valid)
			sample_r <= adc_data;
	end

	// one-pole step y += a*(x-y); zero step at x==y keeps unity dc gain
	assign x_ext = {sample_r, 12'h000};
	assign diff  = 29'(x_ext) - 29'(filt_r);
	assign prod  = diff * $signed({1'b0, hofc_pkg::LP_COEF[lp_eff[2:0] == 3'h7 ? 3'h0 :
		lp_eff]});

	// code 7 loads the sample straight through
	always_comb
	begin
		if (lp_eff == hofc_pkg::LP_BYPASS)
			filt_nxt = x_ext;
		else
			filt_nxt = 28'(29'(filt_r) + prod[40:12]);
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			filt_r <= 28'sh000_0000;
		else if (lp_tick)
			filt_r <= filt_nxt;
	end

	a_dc_gain: assert property (@(posedge clock) disable iff (!arst_n)
		(lp_tick && filt_r == x_ext) |=> (filt_r == $past(filt_r)))
		else $error("filter moved at steady state");

	a_bypass: assert property (@(posedge clock) disable iff (!arst_n)
		(lp_tick && lp_eff == 3'h7) |=> (filt_r[27:12] == $past(sample_r)))
		else $error("bypass did not pass sample");

	// ****************************************
	// limiter to 12-bit code
	// ****************************************
	// bipolar result around mid-scale, saturated at both ends
	assign filt_int = filt_r[27:12];

	always_comb
	begin
		if (filt_int > 16'sd2047)
			dsp_code = hofc_pkg::CODE_FULL;
		else if (filt_int < -16'sd2048)
			dsp_code = 12'h000;
		else
			dsp_code = filt_int[11:0] ^ hofc_pkg::CODE_MID;
	end

	a_limit_12: assert property (@(posedge clock) disable iff (!arst_n)
		(filt_int > 16'sd2047) |-> (dsp_code == 12'hfff))
		else $error("limiter did not saturate");

	// ****************************************
	// interpolation filter
	// ****************************************
	// accumulator after this tick's step; its fraction is zero at each lp tick
	assign acc_sum = acc_r + 16'({{3{delta_r[12]}}, delta_r});

	// linear ramp in 16 steps of q4 toward each new result, never bypassed
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			acc_r   <= 16'h0000;
			delta_r <= 13'sh0000;
		end
		else if (interp_tick)
		begin
			acc_r <= acc_sum;
			if (lp_tick)
				delta_r <= $signed({1'b0, dsp_code}) - $signed({1'b0, acc_sum[15:4]});
		end
	end

	assign interp_code = acc_r[15:4];

	// ****************************************
	// clamp and error override
	// ****************************************
	// low limit first, then high limit, error forces full scale
	always_comb
	begin
		lo_c = (interp_code < lo_eff) ? lo_eff : interp_code;
		out_nxt = (lo_c > hi_eff) ? hi_eff : lo_c;
		if (uncorr)
			out_nxt = hofc_pkg::CODE_FULL;
	end

	// dac code and strobe at the 256 khz rate
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dac_code_r   <= 12'h000;
			dac_strobe_r <= 1'b0;
		end
		else
		begin
			dac_strobe_r <= interp_tick;
			if (interp_tick)
				dac_code_r <= out_nxt;
		end
	end

	assign readdata    = readdata_r;
	assign waitrequest = wait_r;
	assign dac_code    = dac_code_r;
	assign dac_strobe  = dac_strobe_r;
	assign cfg_error   = uncorr;

	a_clamp_high: assert property (@(posedge clock) disable iff (!arst_n)
		(interp_tick && !uncorr) |=> (dac_code_r <= $past(hi_eff)))
		else $error("code above high clamp");

	a_clamp_low: assert property (@(posedge clock) disable iff (!arst_n)
		(interp_tick && !uncorr && lo_eff <= hi_eff) |=> (dac_code_r >= $past(lo_eff)))
		else $error("code below low clamp");

	a_err_full: assert property (@(posedge clock) disable iff (!arst_n)
		(interp_tick && uncorr) |=> (dac_code_r == 12'hfff) && dac_strobe_r)
		else $error("error did not force full scale");
endmodule : hofc_top

// File: tb/hofc_dac_model.sv
// hofc_dac_model: output dac and pin as seen from outside the block
// assumes dac_code is registered and dac_strobe is a one-cycle pulse
`timescale 1ns/100ps
module hofc_dac_model #(
	parameter int VDD_MV = 5000 // supply in millivolts
) (
	input  wire logic        clock,      // system clock
	input  wire logic        arst_n,     // async reset, active low
	input  wire logic [11:0] dac_code,   // code from the block
	input  wire logic        dac_strobe, // new code pulse
	output int               vout_mv,    // pin level in millivolts
	output int               period      // clocks between last two strobes
);
	int cnt;

	// pin level is code/4096 of supply, latched at each strobe
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			vout_mv <= 0;
			period  <= 0;
			cnt     <= 1;
		end
		else if (dac_strobe)
		begin
			vout_mv <= int'(dac_code) * VDD_MV / 4096;
			period  <= cnt;
			cnt     <= 1;
		end
		else
			cnt <= cnt + 1;
	end
endmodule : hofc_dac_model

// File: tb/tb.sv
// tb: self-checking bench for the hall output filter and clamp block
// assumes hofc_top and hofc_dac_model compiled first, 100 mhz clock
`timescale 1ns/100ps
module tb;
	logic        clock, arst_n, read, write, adc_valid;
	logic [15:0] adc_data;
	logic [47:0] cfg_image;
	logic [4:0]  address;
	logic [31:0] writedata, readdata, q;
	logic        waitrequest, dac_strobe, cfg_error;
	logic [11:0] dac_code;
	int          fails, n_checks, vout_mv, period;

	hofc_top hofc_top_inst (.clock(clock), .arst_n(arst_n), .adc_data(adc_data),
		.adc_valid(adc_valid), .cfg_image(cfg_image), .cfg_row_par(3'h0),
		.cfg_col_par(16'h0000), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(4'hf), .readdata(readdata),
		.waitrequest(waitrequest), .dac_code(dac_code), .dac_strobe(dac_strobe),
		.cfg_error(cfg_error));
	hofc_dac_model hofc_dac_model_inst (.clock(clock), .arst_n(arst_n),
		.dac_code(dac_code), .dac_strobe(dac_strobe), .vout_mv(vout_mv), .period(period));

	// ****************************************
	// helpers
	// ****************************************
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic report_and_stop();
		if (fails == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop

	// one avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge clock);
		read      <= !wr;
		write     <= wr;
		address   <= a;
		writedata <= d;
		do
			@(posedge clock);
		while (waitrequest !== 1'b0);
		q = readdata;
		read  <= 1'b0;
		write <= 1'b0;
	endtask : bus

	// wait for a number of dac strobes, bounded
	task automatic strobes(input int n);
		int k;
		repeat (n)
		begin
			k = 0;
			do
			begin
				@(posedge clock);
				k++;
			end
			while (dac_strobe !== 1'b1 && k < 1000);
			if (k >= 1000)
				fails++;
		end
	endtask : strobes

	task automatic sample(input logic [15:0] d);
		@(posedge clock);
		adc_data  <= d;
		adc_valid <= 1'b1;
		@(posedge clock);
		adc_valid <= 1'b0;
	endtask : sample

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs();
		bus(0, 5'h00, 0); check("lp reset", q, 32'h0);
		bus(0, 5'h04, 0); check("cl reset", q, 32'h0);
		bus(0, 5'h08, 0); check("ch reset", q, 32'hfff);
		bus(1, 5'h14, 32'h5); bus(0, 5'h14, 0); check("unmapped", q, 32'h0);
		bus(1, 5'h04, 32'hffff_fa00); bus(0, 5'h04, 0); check("cl width", q, 32'ha00);
		bus(1, 5'h00, 32'h7); bus(0, 5'h00, 0); check("lp width", q, 32'h7);
		bus(1, 5'h04, 32'h0);
		bus(1, 5'h0c, 32'h1);
	endtask : t_regs

	task automatic t_bypass_sat();
		sample(16'h7fff);
		strobes(49);
		check("saturated code", 32'(dac_code), 32'hfff);
		check("strobe period", 32'(period), 32'(hofc_pkg::INTERP_CYC));
		@(posedge clock);
		check("strobe width", 32'(dac_strobe), 32'h0);
		bus(1, 5'h08, 32'hc00);
		strobes(2);
		check("high clamp", 32'(dac_code), 32'hc00);
	endtask : t_bypass_sat

	task automatic t_dc_gain();
		bus(1, 5'h08, 32'hfff);
		sample(16'h01f8);
		strobes(49);
		check("bypass code", 32'(dac_code), 32'h9f8);
		bus(1, 5'h00, 32'h6);
		sample(16'h0200);
		strobes(113);
		check("dc gain", 32'(dac_code >= 12'h9ff && dac_code <= 12'ha01), 32'h1);
	endtask : t_dc_gain

	task automatic t_low_clamp();
		bus(1, 5'h04, 32'hb00);
		strobes(2);
		check("low clamp", 32'(dac_code), 32'hb00);
		bus(1, 5'h08, 32'ha80);
		strobes(2);
		check("inverted limits", 32'(dac_code), 32'ha80);
	endtask : t_low_clamp

	task automatic t_parity();
		cfg_image[3] <= 1'b1;
		bus(0, 5'h10, 0);
		check("one bit fixed", 32'(q[1:0]), 32'h2);
		check("no error", 32'(cfg_error), 32'h0);
		cfg_image[20] <= 1'b1;
		bus(0, 5'h10, 0);
		check("uncorrectable", 32'(q[0]), 32'h1);
		check("error flag", 32'(cfg_error), 32'h1);
		strobes(2);
		check("error code", 32'(dac_code), 32'hfff);
		check("pin at supply", 32'(vout_mv >= 4850), 32'h1);
		bus(0, 5'h10, 0);
		check("status code", 32'(q[27:16]), 32'hfff);
		cfg_image <= 48'h0;
		strobes(3);
		check("error released", 32'(dac_code), 32'ha80);
	endtask : t_parity

	// ****************************************
	// clock, reset, sequence, watchdog
	// ****************************************
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	initial
	begin
		#1_000_000;
		fails++;
		report_and_stop();
	end

	initial
	begin
		fails = 0;
		n_checks = 0;
		arst_n = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 5'h00;
		writedata = 32'h0;
		adc_data = 16'h0000;
		adc_valid = 1'b0;
		cfg_image = 48'h0;
		repeat (16) @(posedge clock);
		arst_n <= 1'b1;
		t_regs();
		t_bypass_sat();
		t_dc_gain();
		t_low_clamp();
		t_parity();
		report_and_stop();
	end
endmodule : tb
